/* inc/smsup_regs.vh */
// smsup_regs.vh: constants for the lamp switch mode supervisor and serial port
// assumes: included by bare name from design files; definitions only
`ifndef SMSUP_REGS_VH
`define SMSUP_REGS_VH

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define SMSUP_FRAME_BITS     16
`define SMSUP_WD_BIT         15
`define SMSUP_ADDR_MSB       14
`define SMSUP_ADDR_LSB       10
`define SMSUP_DATA_MSB       9
`define SMSUP_ADDR_ON        5'h00
`define SMSUP_ADDR_CFG       5'h01

// ----------------------------------------------------------------------
// modes
// ----------------------------------------------------------------------
`define SMSUP_MODE_SLEEP     2'h0
`define SMSUP_MODE_NORMAL    2'h1
`define SMSUP_MODE_FAILSAFE  2'h2
`define SMSUP_MODE_FAULT     2'h3

// ----------------------------------------------------------------------
// configuration bits and reset values
// ----------------------------------------------------------------------
`define SMSUP_CFG_VDDFAIL_EN 0
`define SMSUP_CFG_OV_GATE    1
`define SMSUP_CFG_RESET      10'h000
`define SMSUP_ON_RESET       4'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SMSUP_CLK_MHZ        250
`define SMSUP_FILT_NS        1000
`define SMSUP_FILT_CYC       ((`SMSUP_FILT_NS * `SMSUP_CLK_MHZ + 999) / 1000)
`define SMSUP_WDTO_US        10000
`define SMSUP_WDTO_CYC       (`SMSUP_WDTO_US * `SMSUP_CLK_MHZ)

`endif

/* design/smsup_sync.v */
// smsup_sync.v: two flip-flop synchroniser, one per bit
// assumes: inputs asynchronous to core_clk
`timescale 1ns/100ps
module smsup_sync #(
	parameter W = 1
) (
	// clock and reset
	input  wire         core_clk,
	input  wire         rst_n,
	// data
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;

	// first stage feeds only the second
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end
	assign sync_out = sync_r;
endmodule

/* design/smsup_filt.v */
// smsup_filt.v: direct-input hold filter, output follows input once stable for a count
// assumes: input already synchronised to core_clk
`timescale 1ns/100ps
module smsup_filt #(
	parameter CNT = 250,
	parameter CW  = 12
) (
	// clock and reset
	input  wire core_clk,
	input  wire rst_n,
	// data
	input  wire raw_in,
	output reg  filt_out
);
	reg [CW-1:0] cnt_r;

	// count while input differs from output, take it once stable
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r    <= {CW{1'b0}};
			filt_out <= 1'b0;
		end else if (raw_in == filt_out) begin
			cnt_r <= {CW{1'b0}};
		end else if (cnt_r == CNT[CW-1:0] - 1'b1) begin
			cnt_r    <= {CW{1'b0}};
			filt_out <= raw_in;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end
endmodule

/* design/smsup_top.v */
// smsup_top.v: operating-mode supervisor and 16-bit serial command port of a quad lamp switch
// assumes: all pins asynchronous to core_clk; serial clock well below core_clk/8
// Behaviour
// R01: serial input bit sampled on serial clock falling edge.
// R02: master sends sixteen bits per frame, D15 first, D0 last.
// R03: five-bit address field in frame selects the target register.
// R04: serial output driven only while chip select low, else released.
// R05: serial output changes on rising edge; master captures on falling edge.
// R06: status word shifted out MSB first, in full duplex with command.
// R07: strap open enables watchdog; after timeout outputs follow direct inputs.
// R08: strap low disables watchdog; outputs follow inputs only on enabled supply loss.
// R09: wake is OR of reset pin, wake pin and four filtered inputs.
// R10: fail is enabled supply loss or watchdog timeout with strap not grounded.
// R11: fault is OR of channel flags, undervoltage, and gated overvoltage.
// R12: wake low forces Sleep with all outputs off.
// R13: wake, no fail, no fault gives Normal; watchdog runs only if enabled.
// R14: wake with fail and no fault gives Fail-safe; outputs follow inputs.
// R15: wake with fault gives Fault; faulted outputs off, autoretry kept active.
// R16: in Sleep every configurable feature acts as zero.
// R17: device starts in Sleep after reset before any input change.
// R18: Fail-safe reverts configuration to defaults; outputs from parallel inputs only.
// R19: Normal lets serial link control each output; PWM range 100 to 400 Hz (no PWM here; outputs are static on_r levels).
// R20: word transferred on chip select rise; status loaded on chip select fall.
// R21: serial clock and input ignored while chip select high.
// R22: master toggles watchdog bit D15 within the minimum timeout.
// R23: each direct input passes a hold filter before use.
// R24: mode chosen every cycle: Sleep, then Fault, then Fail-safe, then Normal.
`timescale 1ns/100ps
`include "smsup_regs.vh"
module smsup_top #(
	parameter WDTO_CYC = `SMSUP_WDTO_CYC,
	parameter FILT_CYC = `SMSUP_FILT_CYC
) (
	// clock and reset
	input  wire        core_clk,
	input  wire        rst_n,
	// serial link pins
	input  wire        spi_cs_n,
	input  wire        spi_sclk,
	input  wire        spi_si,
	output reg         spi_so,
	output reg         spi_so_oe,
	// device pins
	input  wire        reset_pin,
	input  wire        wake_pin,
	input  wire [3:0]  direct_in,
	input  wire        failsafe_strap_input,
	// protection and supply status
	input  wire        vdd_fail,
	input  wire [3:0]  overcurrent_flag,
	input  wire [3:0]  overtemperature_flag,
	input  wire [3:0]  severe_short_flag,
	input  wire        undervoltage_flag,
	input  wire        overvoltage_flag,
	// outputs
	output reg  [3:0]  power_output_channels,
	output reg  [1:0]  mode,
	output reg         autoretry_en,
	output reg         watchdog_timeout,
	output reg         circuit_power_en,
	output reg  [9:0]  cfg_out
);
	// ----------------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------------
	// chip select travels inverted, so the cleared stages read as deselected
	wire [12:0] pins_s;
	smsup_sync #(
		.W (13)
	) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.async_in ({~spi_cs_n, spi_sclk, spi_si, reset_pin, wake_pin, direct_in,
		            failsafe_strap_input, vdd_fail, undervoltage_flag, overvoltage_flag}),
		.sync_out (pins_s)
	);
	// split the synchronised word back into pins
	wire       cs_n_s  = ~pins_s[12];
	wire       sclk_s  = pins_s[11];
	wire       si_s    = pins_s[10];
	wire       rst_s   = pins_s[9];
	wire       wake_s  = pins_s[8];
	wire [3:0] din_s   = pins_s[7:4];
	wire       fsi_s   = pins_s[3];
	wire       vddf_s  = pins_s[2];
	wire       uv_s    = pins_s[1];
	wire       ov_s    = pins_s[0];

	// per-channel protection flags
	wire [3:0] oc_s;
	wire [3:0] ot_s;
	wire [3:0] sc_s;
	smsup_sync #(
		.W (12)
	) u_sync_flags (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.async_in ({overcurrent_flag, overtemperature_flag, severe_short_flag}),
		.sync_out ({oc_s, ot_s, sc_s})
	);

	// ----------------------------------------------------------------------
	// direct input filters
	// ----------------------------------------------------------------------
	wire [3:0] din_f;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_filt
			smsup_filt #(
				.CNT (FILT_CYC),
				.CW  (12)
			) u_filt (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.raw_in   (din_s[gi]), // R23
				.filt_out (din_f[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------------
	// edge detection of link, reset and wake pins
	// ----------------------------------------------------------------------
	reg cs_d_r;
	reg sclk_d_r;
	reg rst_d_r;
	reg wake_d_r;

	// previous pin levels for edge finding, reset to the idle levels
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_d_r   <= 1'b1;
			sclk_d_r <= 1'b0;
			rst_d_r  <= 1'b0;
			wake_d_r <= 1'b0;
		end else begin
			cs_d_r   <= cs_n_s;
			sclk_d_r <= sclk_s;
			rst_d_r  <= rst_s;
			wake_d_r <= wake_s;
		end
	end
	wire cs_fall   = cs_d_r & ~cs_n_s;
	wire cs_rise   = ~cs_d_r & cs_n_s;
	wire sclk_fall = sclk_d_r & ~sclk_s & ~cs_n_s; // R21
	wire sclk_rise = ~sclk_d_r & sclk_s & ~cs_n_s; // R21

	// ----------------------------------------------------------------------
	// mode terms
	// ----------------------------------------------------------------------
	reg  [9:0] cfg_r;
	reg  [3:0] on_r;
	reg        wd_to_r;
	reg        vdd_lat_r;
	wire       wd_enabled = fsi_s;                                           // R07 R08
	wire       wake_t  = rst_s | wake_s | (|din_f);                          // R09
	wire       fail_t  = (vddf_s & cfg_r[`SMSUP_CFG_VDDFAIL_EN]) |
	                     vdd_lat_r |
	                     (wd_to_r & wd_enabled);                             // R10
	wire       fault_t = (|oc_s) | (|ot_s) | (|sc_s) | uv_s |
	                     (ov_s & cfg_r[`SMSUP_CFG_OV_GATE]);                 // R11
	reg  [1:0] mode_nxt;

	// priority: sleep, fault, fail-safe, normal
	always @* begin
		if (!wake_t) begin
			mode_nxt = `SMSUP_MODE_SLEEP;    // R12 R24
		end else if (fault_t) begin
			mode_nxt = `SMSUP_MODE_FAULT;    // R15 R24
		end else if (fail_t) begin
			mode_nxt = `SMSUP_MODE_FAILSAFE; // R14 R24
		end else begin
			mode_nxt = `SMSUP_MODE_NORMAL;   // R13 R24
		end
	end

	// ----------------------------------------------------------------------
	// serial shift engine
	// ----------------------------------------------------------------------
	reg [15:0] rx_r;
	reg [15:0] tx_r;
	reg [4:0]  bit_cnt_r;
	reg        first_r;
	reg        wd_last_r;
	reg        wd_kick_r;
	// status: mode, timeout, fault, fail, three spare, then channel and supply flags
	wire [15:0] status_word = {mode, wd_to_r, fault_t, fail_t, 3'h0,
	                           oc_s | sc_s,
	                           ot_s | {3'h0, uv_s}};
	wire        frame_ok    = cs_rise & (bit_cnt_r == 5'd16);
	wire [4:0]  frame_addr  = rx_r[`SMSUP_ADDR_MSB:`SMSUP_ADDR_LSB];
	// defaults come back in sleep, in fail-safe and on a reset pin rise
	wire        cfg_clear   = (mode == `SMSUP_MODE_SLEEP) | (mode == `SMSUP_MODE_FAILSAFE) |
	                          (rst_s & ~rst_d_r);

	// shift in on falling, out on rising, load at frame start
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_r      <= 16'h0000;
			tx_r      <= 16'h0000;
			bit_cnt_r <= 5'h00;
			first_r   <= 1'b0;
		end else if (cs_fall) begin
			tx_r      <= status_word; // R20
			bit_cnt_r <= 5'h00;
			first_r   <= 1'b1;
		end else begin
			if (sclk_fall) begin
				rx_r <= {rx_r[14:0], si_s}; // R01 R06
				if (bit_cnt_r != 5'd31) begin
					bit_cnt_r <= bit_cnt_r + 5'd1;
				end
			end
			if (sclk_rise) begin
				first_r <= 1'b0;
				if (!first_r) begin
					tx_r <= {tx_r[14:0], 1'b0}; // R05 R06
				end
			end
		end
	end

	// serial output driver, released while chip select high
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			spi_so    <= 1'b0;
			spi_so_oe <= 1'b0;
		end else begin
			spi_so_oe <= ~cs_n_s;            // R04
			spi_so    <= cs_n_s ? 1'b0 : tx_r[15]; // R05
		end
	end

	// ----------------------------------------------------------------------
	// register write and configuration
	// ----------------------------------------------------------------------
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r     <= `SMSUP_CFG_RESET;
			on_r      <= `SMSUP_ON_RESET;
			wd_last_r <= 1'b0;
			wd_kick_r <= 1'b0;
		end else begin
			wd_kick_r <= 1'b0;
			if (frame_ok) begin
				wd_kick_r <= (rx_r[`SMSUP_WD_BIT] != wd_last_r) |
				             ((mode == `SMSUP_MODE_FAILSAFE) & rx_r[`SMSUP_WD_BIT]); // R22
				wd_last_r <= rx_r[`SMSUP_WD_BIT];
			end
			if (cfg_clear) begin
				cfg_r <= `SMSUP_CFG_RESET; // R16 R18
				on_r  <= `SMSUP_ON_RESET;  // R16 R18
			end else if (frame_ok) begin
				case (frame_addr) // R03 R20
					`SMSUP_ADDR_ON: begin
						on_r <= rx_r[3:0];
					end
					`SMSUP_ADDR_CFG: begin
						cfg_r <= rx_r[`SMSUP_DATA_MSB:0];
					end
					default: begin
						on_r <= on_r;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------------
	// supply-loss latch
	// ----------------------------------------------------------------------
	// the fail-safe revert clears the enable bit, so an enabled supply loss is
	// held here until sleep, or until a frame with the watchdog bit set arrives on good supply
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			vdd_lat_r <= 1'b0;
		end else if (vddf_s & cfg_r[`SMSUP_CFG_VDDFAIL_EN]) begin
			vdd_lat_r <= 1'b1; // R10
		end else if ((mode == `SMSUP_MODE_SLEEP) || (frame_ok && rx_r[`SMSUP_WD_BIT] && !vddf_s)) begin
			vdd_lat_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------------
	reg [31:0] wd_cnt_r;
	// a rising reset or wake pin restarts the count
	wire       wd_start = (rst_s & ~rst_d_r) | (wake_s & ~wake_d_r);
	wire       wd_limit = (wd_cnt_r == WDTO_CYC - 1);

	// count in normal mode; a timeout meeting a kick in the same cycle still lands
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_cnt_r <= 32'h00000000;
			wd_to_r  <= 1'b0;
		end else if (!wd_enabled || mode == `SMSUP_MODE_SLEEP || wd_start) begin
			wd_cnt_r <= 32'h00000000; // R08
			wd_to_r  <= 1'b0;
		end else if (mode == `SMSUP_MODE_NORMAL && !wd_to_r && wd_limit) begin
			wd_to_r <= 1'b1; // R07 R13
		end else if (wd_kick_r) begin
			wd_cnt_r <= 32'h00000000;
			wd_to_r  <= 1'b0;
		end else if (mode == `SMSUP_MODE_NORMAL && !wd_to_r) begin
			wd_cnt_r <= wd_cnt_r + 32'h00000001;
		end
	end

	// ----------------------------------------------------------------------
	// output control
	// ----------------------------------------------------------------------
	// channels with a protection flag set
	wire [3:0] ch_fault = oc_s | ot_s | sc_s;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode                  <= `SMSUP_MODE_SLEEP; // R17
			power_output_channels <= 4'h0;
			autoretry_en          <= 1'b0;
			watchdog_timeout      <= 1'b0;
			circuit_power_en      <= 1'b0;
			cfg_out               <= `SMSUP_CFG_RESET;
		end else begin
			mode             <= mode_nxt;
			watchdog_timeout <= wd_to_r;
			circuit_power_en <= (mode_nxt != `SMSUP_MODE_SLEEP);         // R16
			autoretry_en     <= (mode_nxt == `SMSUP_MODE_FAULT);         // R15
			cfg_out          <= (mode_nxt == `SMSUP_MODE_SLEEP) ? `SMSUP_CFG_RESET : cfg_r; // R16
			// lamp outputs per mode
			case (mode_nxt)
				`SMSUP_MODE_NORMAL: begin
					power_output_channels <= on_r;                  // R19
				end
				`SMSUP_MODE_FAILSAFE: begin
					power_output_channels <= din_f;                 // R14 R18 R07 R08
				end
				`SMSUP_MODE_FAULT: begin
					power_output_channels <= (fail_t ? din_f : on_r) & ~ch_fault; // R15
				end
				default: begin
					power_output_channels <= 4'h0;                  // R12
				end
			endcase
		end
	end
endmodule

/* tb/smsup_spi_master.sv */
// smsup_spi_master.sv: serial bus master model for the lamp switch port
// assumes: clock and data idle low (pull-downs); frames started by the bench
`timescale 1ns/100ps
module smsup_spi_master (
	// serial pins
	output logic cs_n,
	output logic sclk,
	output logic si,
	input  wire  so
);
	// idle levels outside frames
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si   = 1'b0;
	end
	// one frame of n bits msb first, 80 ns clock, clock stands low between frames
	task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = 16'h0000;
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			#40 sclk = 1'b1;
			si = tx[15-i];
			#40 sclk = 1'b0;
			rx = {rx[14:0], so};
		end
		#40 cs_n = 1'b1;
		si = 1'b0;
		#400;
	endtask
endmodule

/* tb/smsup_top_sva.sv */
// smsup_top_sva.sv: port assertions for the mode supervisor and serial port
// assumes: bound to smsup_top; direct-input filter short as in the bench
`timescale 1ns/100ps
`include "smsup_regs.vh"
module smsup_top_sva #(
	parameter int FILT_CYC = 4
) (
	// clock and reset
	input wire       core_clk,
	input wire       rst_n,
	// pins
	input wire       spi_cs_n,
	input wire       spi_so_oe,
	input wire       reset_pin,
	input wire       wake_pin,
	input wire [3:0] direct_in,
	input wire       failsafe_strap_input,
	input wire [3:0] overcurrent_flag,
	input wire [3:0] overtemperature_flag,
	input wire [3:0] severe_short_flag,
	input wire       undervoltage_flag,
	input wire       overvoltage_flag,
	// outputs
	input wire [3:0] power_output_channels,
	input wire [1:0] mode,
	input wire       autoretry_en,
	input wire       watchdog_timeout,
	input wire [9:0] cfg_out
);
	localparam int QW = FILT_CYC + 6;
	// any fault source at the pins
	wire flt_in = |{overcurrent_flag, overtemperature_flag, severe_short_flag, undervoltage_flag,
	                overvoltage_flag & cfg_out[`SMSUP_CFG_OV_GATE]};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// no wake source for a while
	sequence s_quiet;
		(!reset_pin && !wake_pin && direct_in == 4'h0)[*8];
	endsequence
	// woken with a fault source held
	sequence s_wflt;
		(wake_pin && flt_in)[*4];
	endsequence
	property p_wake; s_quiet |-> ##[0:QW] mode == `SMSUP_MODE_SLEEP; endproperty
	a_wake: assert property (p_wake) else $error("no sleep without wake");
	property p_fault; s_wflt |-> ##[0:6] mode == `SMSUP_MODE_FAULT; endproperty
	a_fault: assert property (p_fault) else $error("no fault mode");
	property p_retry; (mode == `SMSUP_MODE_FAULT)[*2] |-> autoretry_en; endproperty
	a_retry: assert property (p_retry) else $error("autoretry off in fault");
	property p_wdt; (watchdog_timeout && failsafe_strap_input && wake_pin && !flt_in)[*4]
		|-> ##[0:4] mode == `SMSUP_MODE_FAILSAFE; endproperty
	a_wdt: assert property (p_wdt) else $error("no failsafe on timeout");
	property p_fsout; (mode == `SMSUP_MODE_FAILSAFE && $stable(direct_in))[*8]
		|-> ##[0:QW] power_output_channels == direct_in; endproperty
	a_fsout: assert property (p_fsout) else $error("outputs not following inputs");
	property p_cs_oe; spi_cs_n[*6] |-> !spi_so_oe; endproperty
	a_cs_oe: assert property (p_cs_oe) else $error("output driven with cs high");
	property p_sleep_off; (mode == `SMSUP_MODE_SLEEP)[*2] |-> power_output_channels == 4'h0; endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("output on in sleep");
	property p_sleep_cfg; (mode == `SMSUP_MODE_SLEEP)[*2] |-> cfg_out == 10'h000; endproperty
	a_sleep_cfg: assert property (p_sleep_cfg) else $error("config set in sleep");
endmodule
bind smsup_top smsup_top_sva #(.FILT_CYC(FILT_CYC)) u_sva (
	.core_clk(core_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_so_oe(spi_so_oe),
	.reset_pin(reset_pin), .wake_pin(wake_pin), .direct_in(direct_in),
	.failsafe_strap_input(failsafe_strap_input), .overcurrent_flag(overcurrent_flag),
	.overtemperature_flag(overtemperature_flag), .severe_short_flag(severe_short_flag),
	.undervoltage_flag(undervoltage_flag), .overvoltage_flag(overvoltage_flag),
	.power_output_channels(power_output_channels), .mode(mode), .autoretry_en(autoretry_en),
	.watchdog_timeout(watchdog_timeout), .cfg_out(cfg_out));

/* tb/smsup_top_tb.sv */
// smsup_top_tb.sv: self-checking bench for the mode supervisor and serial port
// assumes: master model and bound checker compiled alongside
`timescale 1ns/100ps
`include "smsup_regs.vh"
module smsup_top_tb;
	localparam int WDT = 1000;
	localparam logic [1:0] SLP = `SMSUP_MODE_SLEEP, NRM = `SMSUP_MODE_NORMAL;
	localparam logic [1:0] FSF = `SMSUP_MODE_FAILSAFE, FLT = `SMSUP_MODE_FAULT;
	logic core_clk = 0, rst_n = 0, reset_pin = 0, wake_pin = 0, strap = 0, vdd_fail = 0, uv = 0, ov = 0;
	logic [3:0] din = 0, oc = 0, ot = 0, sc = 0, hs;
	logic so, oe, retry, wdto, pwr;
	wire cs_n, sclk, si;
	logic [1:0] mode;
	logic [9:0] cfg;
	logic [15:0] rx;
	int miscompares = 0, n_checks = 0;
	// 250 MHz core clock
	initial forever #2 core_clk = ~core_clk;
	smsup_top #(.WDTO_CYC(WDT), .FILT_CYC(4)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_si(si),
		.spi_so(so), .spi_so_oe(oe), .reset_pin(reset_pin), .wake_pin(wake_pin), .direct_in(din),
		.failsafe_strap_input(strap), .vdd_fail(vdd_fail), .overcurrent_flag(oc),
		.overtemperature_flag(ot), .severe_short_flag(sc), .undervoltage_flag(uv),
		.overvoltage_flag(ov), .power_output_channels(hs), .mode(mode), .autoretry_en(retry),
		.watchdog_timeout(wdto), .circuit_power_en(pwr), .cfg_out(cfg));
	smsup_spi_master u_mst (.cs_n(cs_n), .sclk(sclk), .si(si), .so(oe ? so : 1'bz));
	// exact four-state compare
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// step to just after a rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// bounded wait for a mode, then let registered outputs settle
	task automatic wait_mode(input logic [1:0] m);
		int i;
		for (i = 0; i < 3000 && mode !== m; i++)
			@(posedge core_clk);
		if (i == 3000) begin
			$display("[FAIL] mode expected %h seen %h", m, mode);
			miscompares++;
			finish_test();
		end
		tick(6);
	endtask
	// one frame: watchdog bit, address, data
	task automatic frm(input logic wd, input logic [4:0] a, input logic [9:0] d, input int n = 16);
		tick(1);
		u_mst.xfer({wd, a, d}, n, rx);
	endtask
	task automatic t_normal;
		wake_pin = 1;
		wait_mode(NRM);
		chk("pwr", 1, pwr);
		vdd_fail = 1;
		tick(20);
		chk("mode", NRM, mode);
		vdd_fail = 0;
		frm(0, `SMSUP_ADDR_ON, 10'h005);
		chk("status", 16'h4000, rx);
		chk("hs", 4'h5, hs);
		frm(1, `SMSUP_ADDR_ON, 10'h00f, 15);
		chk("hs", 4'h5, hs);
		frm(1, `SMSUP_ADDR_CFG, 10'h001);
		chk("cfg", 10'h001, cfg);
		frm(0, 5'h02, 10'h3fe);
		chk("cfg", 10'h001, cfg);
		tick(1200);
		chk("wdto", 0, wdto);
		$display("t_normal done");
	endtask
	task automatic t_fsafe;
		din = 4'ha;
		vdd_fail = 1;
		wait_mode(FSF);
		tick(12);
		chk("hs", 4'ha, hs);
		chk("cfg", 10'h000, cfg);
		vdd_fail = 0;
		frm(1, `SMSUP_ADDR_ON, 10'h000);
		wait_mode(NRM);
		din = 4'h0;
		$display("t_fsafe done");
	endtask
	task automatic t_wdog;
		strap = 1;
		frm(0, `SMSUP_ADDR_ON, 10'h000);
		frm(1, `SMSUP_ADDR_ON, 10'h000);
		frm(0, `SMSUP_ADDR_ON, 10'h000);
		chk("wdto", 0, wdto);
		tick(WDT);
		wait_mode(FSF);
		chk("wdto", 1, wdto);
		din = 4'h3;
		tick(16);
		chk("hs", 4'h3, hs);
		oc[0] = 1;
		wait_mode(FLT);
		chk("hs", 4'h2, hs);
		oc[0] = 0;
		wait_mode(FSF);
		frm(1, `SMSUP_ADDR_ON, 10'h000);
		chk("status", 16'ha800, rx);
		strap = 0;
		wait_mode(NRM);
		din = 4'h0;
		$display("t_wdog done");
	endtask
	task automatic t_fault;
		frm(0, `SMSUP_ADDR_ON, 10'h00f);
		chk("hs", 4'hf, hs);
		for (int k = 0; k < 4; k++) begin
			{uv, sc[1], ot[1], oc[1]} = 4'h1 << k;
			wait_mode(FLT);
			chk("retry", 1, retry);
			if (k < 3) chk("hs", 4'hd, hs);
			{uv, sc[1], ot[1], oc[1]} = 4'h0;
			wait_mode(NRM);
		end
		ov = 1;
		tick(20);
		chk("mode", NRM, mode);
		frm(0, `SMSUP_ADDR_CFG, 10'h002);
		wait_mode(FLT);
		chk("hs", 4'hf, hs);
		ov = 0;
		wait_mode(NRM);
		chk("cfg", 10'h002, cfg);
		$display("t_fault done");
	endtask
	task automatic t_sleep;
		wake_pin = 0;
		wait_mode(SLP);
		chk("hs", 4'h0, hs);
		chk("cfg", 10'h000, cfg);
		chk("pwr", 0, pwr);
		din = 4'h1;
		tick(1);
		din = 4'h0;
		tick(20);
		chk("mode", SLP, mode);
		reset_pin = 1;
		wait_mode(NRM);
		reset_pin = 0;
		wait_mode(SLP);
		$display("t_sleep done");
	endtask
	// reset, then the scenarios in turn
	initial begin
		repeat (5) @(posedge core_clk);
		#1 rst_n = 1;
		tick(2);
		chk("oe", 0, oe);
		tick(8);
		chk("mode", SLP, mode);
		chk("oe", 0, oe);
		t_normal();
		t_fsafe();
		t_wdog();
		t_fault();
		t_sleep();
		finish_test();
	end
endmodule
